// file: pid_pkg.sv
// Constants, field positions and carrier types for the packet identify data block.
// Assumes a 20 MHz system clock and a classic Wishbone register port.
package pid_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_GENCFG  = 8'h00;
  localparam logic [7:0] REG_CAP     = 8'h04;
  localparam logic [7:0] REG_RELTIME = 8'h08;
  localparam logic [7:0] REG_BCZ     = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_GENCFG  = 16'h8000;
  localparam logic [8:0]  RST_CAP     = 9'h000;
  localparam logic [15:0] RST_RELTIME = 16'h0000;
  localparam logic [15:0] RST_BCZ     = 16'h0000;

  // ---------------------------------------------------------------------------
  // Word indices of the identification data
  // ---------------------------------------------------------------------------
  localparam logic [7:0] W_GENCFG    = 8'h00;
  localparam logic [7:0] W_SPECCFG   = 8'h02;
  localparam logic [7:0] W_SERIAL_LO = 8'h0A;
  localparam logic [7:0] W_SERIAL_HI = 8'h13;
  localparam logic [7:0] W_FWREV_LO  = 8'h17;
  localparam logic [7:0] W_MODEL_HI  = 8'h2E;
  localparam logic [7:0] W_CAP       = 8'h31;
  localparam logic [7:0] W_CAP2      = 8'h32;
  localparam logic [7:0] W_VALID     = 8'h35;
  localparam logic [7:0] W_TIME_LO   = 8'h3F;
  localparam logic [7:0] W_TIME_HI   = 8'h44;
  localparam logic [7:0] W_PKT_REL   = 8'h47;
  localparam logic [7:0] W_SVC_REL   = 8'h48;
  localparam logic [7:0] W_QDEPTH    = 8'h4B;
  localparam logic [7:0] W_MAJOR     = 8'h50;
  localparam logic [7:0] W_MINOR     = 8'h51;
  localparam logic [7:0] W_FSUP_LO   = 8'h52;
  localparam logic [7:0] W_FSUP_HI   = 8'h54;
  localparam logic [7:0] W_FEN_LO    = 8'h55;
  localparam logic [7:0] W_FEN_HI    = 8'h57;
  localparam logic [7:0] W_UDMA_LO   = 8'h58;
  localparam logic [7:0] W_UDMA_HI   = 8'h5A;
  localparam logic [7:0] W_HWRST     = 8'h5D;
  localparam logic [7:0] W_BCZ       = 8'h7E;
  localparam logic [7:0] W_RMSN      = 8'h7F;
  localparam logic [7:0] W_SEC       = 8'h80;
  localparam logic [7:0] W_LAST      = 8'hFF;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CAP_FLAGS_LO   = 8;
  localparam int CAP_BIT_QUEUE  = 14;
  localparam int CAP_BIT_OVL    = 13;
  localparam int CAP_BIT_IORDY  = 11;
  localparam int CAP_REG_PIO3   = 8;
  localparam int PKT_FEAT_BIT   = 4;
  localparam int QDEPTH_MSB     = 4;
  localparam int STAT_BUSY_BIT  = 16;
  localparam int STAT_IDX_LO    = 24;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] data;
  } pid_word_s;

  typedef struct packed {
    logic        abort;
    logic [15:0] limit;
  } pid_cmdres_s;

endpackage

// file: pid_identify.sv
// Identification data generator for a packet-command device, with Wishbone registers.
// Assumes a mirror store of ordinary identify data answering one cycle after its address.
//
// Notes on behaviour
// R1: Every reserved word is sent as all zeros.
// R2: Serial number words 10 to 19 are zeros when the serial option is off.
// R3: Word 49 bit 15 reports interleaved DMA for overlapped DMA commands.
// R4: Word 49 bit 14 reports queuing; when set, bit 13 is forced to one.
// R5: Word 49 bit 13 reports overlapped command operation.
// R6: Word 49 bit 12 is the obsolete software-reset-while-busy flag.
// R7: Word 49 bit 11 reports IORDY; forced to one with PIO mode 3 support.
// R8: Word 49 bit 10 reports that IORDY may be turned off by set features.
// R9: Word 49 bit 9 reports LBA translation, bit 8 reports DMA.
// R10: Word 71 holds the packet-to-bus-release time in microseconds.
// R11: Word 72 holds the service-to-bus-release time in microseconds.
// R12: Word 75 carries only bits 4 to 0, as in ordinary identify data.
// R13: Words 82 to 84 are mirrored, word 82 bit 4 forced to one.
// R14: Words 85 to 87 are mirrored, word 85 bit 4 forced to one.
// R15: Word 126 zero and a non-zero byte count limit abort the command.
// R16: Word 126 non-zero and a zero limit use word 126 as the limit.
// R17: A new word 126 value is reported only after the next hardware reset.
// R18: Listed words are copied from the ordinary identify data.
// R19: Words 1, 3-9, 20-22 and the other listed ranges are reserved.
// R20: The 256 words leave in ascending index order during data-in.
`timescale 1ns/1ps

module pid_identify #(
  parameter logic SERIAL_EN = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 hw_reset_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 id_start_i,
  output logic      [7:0]           mirror_addr_o,
  input  wire logic [15:0]          mirror_data_i,
  output pid_pkg::pid_word_s        word_o,
  output logic                      word_valid_o,
  input  wire logic                 word_ready_i,
  output logic                      id_done_o,
  output logic                      id_busy_o,
  input  wire logic                 cmd_valid_i,
  input  wire logic [15:0]          cmd_bcl_i,
  output pid_pkg::pid_cmdres_s      cmd_res_o,
  output logic                      cmd_done_o
);
  import pid_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PID_IDLE    = 2'b00,
    PID_ADDR    = 2'b01,
    PID_COMPOSE = 2'b10,
    PID_SEND    = 2'b11
  } pid_state_e;

  pid_state_e  state_ff;
  pid_state_e  nxt_state;
  logic [15:0] gencfg_ff;
  logic [8:0]  cap_ff;
  logic [15:0] pkt_rel_ff;
  logic [15:0] svc_rel_ff;
  logic [15:0] bcz_pend_ff;
  logic [15:0] bcz_act_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0]  idx_ff;
  logic [7:0]  maddr_ff;
  pid_word_s   word_ff;
  logic        wvalid_ff;
  logic        done_ff;
  logic        busy_ff;
  pid_cmdres_s cmdres_ff;
  logic        cmddone_ff;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] rd_mux;
  logic [15:0] cap_word;
  logic        is_mirror;
  logic [15:0] nxt_word;
  logic [31:0] wr_val;

  // ---------------------------------------------------------------------------
  // Byte-lane merge for register writes
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] pid_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  // The ack comes one edge after the request; the write lands at the edge
  // where the master samples that ack.
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_we_i & ack_ff;
  // The byte-lane merge starts from the addressed register's current value.
  assign wr_val = pid_merge(rd_mux, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      REG_GENCFG: begin
        rd_mux[15:0] = gencfg_ff;
      end
      REG_CAP: begin
        rd_mux[8:0] = cap_ff;
      end
      REG_RELTIME: begin
        rd_mux = {svc_rel_ff, pkt_rel_ff};
      end
      REG_BCZ: begin
        rd_mux[15:0] = bcz_pend_ff;
      end
      REG_STATUS: begin
        rd_mux[15:0]                      = bcz_act_ff;
        rd_mux[STAT_BUSY_BIT]             = busy_ff;
        rd_mux[STAT_IDX_LO +: 8]          = idx_ff;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (wb_req & ~wb_we_i & ~ack_ff) begin
      rdat_ff <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gencfg_ff <= RST_GENCFG;
    end else if (wb_wr && wb_adr_i == REG_GENCFG) begin
      gencfg_ff <= wr_val[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_ff <= RST_CAP;
    end else if (wb_wr && wb_adr_i == REG_CAP) begin
      cap_ff <= wr_val[8:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_rel_ff <= RST_RELTIME;
      svc_rel_ff <= RST_RELTIME;
    end else if (wb_wr && wb_adr_i == REG_RELTIME) begin
      pkt_rel_ff <= wr_val[15:0];
      svc_rel_ff <= wr_val[31:16];
    end
  end

  // ---------------------------------------------------------------------------
  // Byte-count-zero value
  // ---------------------------------------------------------------------------
  // Software stages a new value; the reported value follows it only on a
  // hardware reset event, so it stays fixed between such events.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcz_pend_ff <= RST_BCZ;
    end else if (wb_wr && wb_adr_i == REG_BCZ) begin
      bcz_pend_ff <= wr_val[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcz_act_ff <= RST_BCZ;
    end else if (hw_reset_i) begin
      bcz_act_ff <= bcz_pend_ff; // R17
    end
  end

  // ---------------------------------------------------------------------------
  // Byte count limit check
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmdres_ff  <= '0;
      cmddone_ff <= 1'b0;
    end else begin
      cmddone_ff <= cmd_valid_i;
      if (cmd_valid_i) begin
        if (bcz_act_ff == 16'h0000 && cmd_bcl_i != 16'h0000) begin
          cmdres_ff.abort <= 1'b1; // R15
          cmdres_ff.limit <= cmd_bcl_i;
        end else if (bcz_act_ff != 16'h0000 && cmd_bcl_i == 16'h0000) begin
          cmdres_ff.abort <= 1'b0; // R16
          cmdres_ff.limit <= bcz_act_ff; // R16
        end else begin
          cmdres_ff.abort <= 1'b0;
          cmdres_ff.limit <= cmd_bcl_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Word content
  // ---------------------------------------------------------------------------
  always_comb begin
    cap_word = 16'h0000;
    cap_word[15:CAP_FLAGS_LO] = cap_ff[7:0]; // R3 R5 R6 R8 R9
    if (cap_ff[CAP_BIT_QUEUE - CAP_FLAGS_LO]) begin
      cap_word[CAP_BIT_OVL] = 1'b1; // R4
    end
    if (cap_ff[CAP_REG_PIO3]) begin
      cap_word[CAP_BIT_IORDY] = 1'b1; // R7
    end
  end

  always_comb begin
    is_mirror = (idx_ff == W_SPECCFG)
             || (idx_ff >= W_FWREV_LO && idx_ff <= W_MODEL_HI)
             || (idx_ff == W_CAP2)
             || (idx_ff == W_VALID)
             || (idx_ff >= W_TIME_LO && idx_ff <= W_TIME_HI)
             || (idx_ff == W_MAJOR)
             || (idx_ff == W_MINOR)
             || (idx_ff >= W_UDMA_LO && idx_ff <= W_UDMA_HI)
             || (idx_ff == W_HWRST)
             || (idx_ff == W_RMSN)
             || (idx_ff == W_SEC)
             || (idx_ff == W_LAST); // R18
  end

  always_comb begin
    nxt_word = 16'h0000; // R1 R19
    if (idx_ff == W_GENCFG) begin
      nxt_word = gencfg_ff;
    end else if (idx_ff >= W_SERIAL_LO && idx_ff <= W_SERIAL_HI) begin
      nxt_word = SERIAL_EN ? mirror_data_i : 16'h0000; // R2
    end else if (idx_ff == W_CAP) begin
      nxt_word = cap_word;
    end else if (idx_ff == W_PKT_REL) begin
      nxt_word = pkt_rel_ff; // R10
    end else if (idx_ff == W_SVC_REL) begin
      nxt_word = svc_rel_ff; // R11
    end else if (idx_ff == W_QDEPTH) begin
      nxt_word[QDEPTH_MSB:0] = mirror_data_i[QDEPTH_MSB:0]; // R12
    end else if (idx_ff >= W_FSUP_LO && idx_ff <= W_FSUP_HI) begin
      nxt_word = mirror_data_i;
      if (idx_ff == W_FSUP_LO) begin
        nxt_word[PKT_FEAT_BIT] = 1'b1; // R13
      end
    end else if (idx_ff >= W_FEN_LO && idx_ff <= W_FEN_HI) begin
      nxt_word = mirror_data_i;
      if (idx_ff == W_FEN_LO) begin
        nxt_word[PKT_FEAT_BIT] = 1'b1; // R14
      end
    end else if (idx_ff == W_BCZ) begin
      nxt_word = bcz_act_ff; // R17
    end else if (is_mirror) begin
      nxt_word = mirror_data_i; // R18
    end
  end

  // ---------------------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PID_IDLE: begin
        if (id_start_i) begin
          nxt_state = PID_ADDR;
        end
      end
      PID_ADDR: begin
        nxt_state = PID_COMPOSE;
      end
      PID_COMPOSE: begin
        nxt_state = PID_SEND;
      end
      PID_SEND: begin
        if (word_ready_i) begin
          nxt_state = (idx_ff == W_LAST) ? PID_IDLE : PID_ADDR;
        end
      end
      default: begin
        nxt_state = PID_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= PID_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_ff   <= 8'h00;
      maddr_ff <= 8'h00;
    end else if (state_ff == PID_IDLE && id_start_i) begin
      idx_ff   <= 8'h00; // R20
      maddr_ff <= 8'h00;
    end else if (state_ff == PID_SEND && word_ready_i && idx_ff != W_LAST) begin
      idx_ff   <= idx_ff + 8'h01; // R20
      maddr_ff <= idx_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff   <= '0;
      wvalid_ff <= 1'b0;
    end else if (state_ff == PID_COMPOSE) begin
      word_ff.idx  <= idx_ff;
      word_ff.data <= nxt_word;
      wvalid_ff    <= 1'b1;
    end else if (state_ff == PID_SEND && word_ready_i) begin
      wvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == PID_SEND) && word_ready_i && (idx_ff == W_LAST);
      busy_ff <= (nxt_state != PID_IDLE);
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_ack_o      = ack_ff;
  assign wb_dat_o      = rdat_ff;
  assign mirror_addr_o = maddr_ff;
  assign word_o        = word_ff;
  assign word_valid_o  = wvalid_ff;
  assign id_done_o     = done_ff;
  assign id_busy_o     = busy_ff;
  assign cmd_res_o     = cmdres_ff;
  assign cmd_done_o    = cmddone_ff;

endmodule

// file: pid_mirror_model.sv
// Behavioural store of ordinary identify data read by the block.
// Assumes the block holds its word index steady while it reads.
`timescale 1ns/1ps
module pid_mirror_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  addr_i,
  output logic      [15:0] data_o
);
  // ------------------------------------------------------------------
  // Store
  // ------------------------------------------------------------------
  // Each word holds its index above and the inverted index below.
  always_ff @(posedge clk_i) begin
    data_o <= {addr_i, ~addr_i};
  end
endmodule

// file: pid_identify_properties.sv
// Concurrent checks on the identify data block, attached by bind.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module pid_identify_properties
  import pid_pkg::*;
#(
  parameter logic SERIAL_EN = 1'b1
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic                 wb_ack_o,
  input wire pid_pkg::pid_word_s   word_o,
  input wire logic                 word_valid_o,
  input wire logic                 word_ready_i,
  input wire logic                 id_done_o,
  input wire logic                 cmd_valid_i,
  input wire logic [15:0]          cmd_bcl_i,
  input wire pid_pkg::pid_cmdres_s cmd_res_o,
  input wire logic                 cmd_done_o
);
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [7:0] acc_idx_ff;
  logic       acc_w;
  assign acc_w = word_valid_o && word_ready_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_idx_ff <= 8'h00;
    end else if (acc_w) begin
      acc_idx_ff <= word_o.idx;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_cmd_done: assert property (cmd_valid_i |=> cmd_done_o)
    else $error("command result late");
  chk_cmd_limit: assert property (cmd_valid_i && cmd_bcl_i != 16'h0000 |=>
    cmd_res_o.limit == $past(cmd_bcl_i)) else $error("limit differs from host value");
  chk_zero_noabort: assert property (cmd_valid_i && cmd_bcl_i == 16'h0000 |=>
    !cmd_res_o.abort) else $error("zero limit aborted");
  chk_word_hold: assert property (word_valid_o && !word_ready_i |=>
    word_valid_o && $stable(word_o)) else $error("word dropped before accept");
  chk_word_order: assert property ($rose(word_valid_o) && word_o.idx != 8'h00 |->
    word_o.idx == acc_idx_ff + 8'h01) else $error("word index out of order");
  chk_resv_zero: assert property (word_valid_o && word_o.idx inside {1, [3:9], [20:22],
    [47:48], 52, [54:62], [69:70], [73:74], [76:79], [91:92], [94:125], [129:254]}
    |-> word_o.data == 16'h0000) else $error("reserved word not zero");
  chk_serial_off: assert property (!SERIAL_EN && word_valid_o &&
    word_o.idx inside {[10:19]} |-> word_o.data == 16'h0000) else $error("serial not zero");
  chk_pkt_bit: assert property (word_valid_o && word_o.idx inside {82, 85} |->
    word_o.data[4]) else $error("packet feature bit clear");
  chk_queue_ovl: assert property (word_valid_o && word_o.idx == 8'h31 &&
    word_o.data[14] |-> word_o.data[13]) else $error("queuing without overlap");
  chk_depth_bits: assert property (word_valid_o && word_o.idx == 8'h4B |->
    word_o.data[15:5] == 11'h000) else $error("queue depth upper bits set");
  chk_done_last: assert property (acc_w && word_o.idx == 8'hFF |-> ##[1:2] id_done_o)
    else $error("no done after last word");
  cov_abort: cover property (cmd_done_o && cmd_res_o.abort);
  cov_last: cover property (acc_w && word_o.idx == 8'hFF);
  cov_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind pid_identify pid_identify_properties #(.SERIAL_EN(SERIAL_EN)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .word_o(word_o), .word_valid_o(word_valid_o),
  .word_ready_i(word_ready_i), .id_done_o(id_done_o), .cmd_valid_i(cmd_valid_i),
  .cmd_bcl_i(cmd_bcl_i), .cmd_res_o(cmd_res_o), .cmd_done_o(cmd_done_o));

// file: tb_packet_device_identify_data.sv
// Self-checking bench for the packet identify data block.
// Assumes the mirror model answers one cycle after each index.
`timescale 1ns/1ps
module tb_packet_device_identify_data;
  import pid_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hw_reset_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        id_start_i = 1'b0;
  logic [7:0]  mirror_addr_o;
  logic [15:0] mirror_data_i;
  pid_word_s   word_o;
  logic        word_valid_o;
  logic        word_ready_i = 1'b1;
  logic        id_done_o;
  logic        id_busy_o;
  logic        cmd_valid_i = 1'b0;
  logic [15:0] cmd_bcl_i = 16'h0;
  pid_cmdres_s cmd_res_o;
  logic        cmd_done_o;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [15:0] gen_exp = RST_GENCFG;
  logic [31:0] rel_exp = 32'h0;
  logic [15:0] w126_exp = RST_BCZ;

  pid_identify #(.SERIAL_EN(1'b0)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .hw_reset_i(hw_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .id_start_i(id_start_i), .mirror_addr_o(mirror_addr_o),
    .mirror_data_i(mirror_data_i), .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .id_done_o(id_done_o), .id_busy_o(id_busy_o),
    .cmd_valid_i(cmd_valid_i), .cmd_bcl_i(cmd_bcl_i), .cmd_res_o(cmd_res_o),
    .cmd_done_o(cmd_done_o));
  pid_mirror_model mirror_u (.clk_i(clk_i), .addr_i(mirror_addr_o), .data_o(mirror_data_i));

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    check(n < 50, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  function automatic logic [15:0] exp_word(input int i, input logic [8:0] c);
    logic [15:0] m;
    m = {i[7:0], ~i[7:0]};
    case (i) inside
      0: return gen_exp;
      2, [23:46], 50, 53, [63:68], 80, 81, 83, 84, [86:90], 93, 127, 128, 255: return m;
      82, 85: return m | 16'h0010;
      49: return {c[7], c[6], c[5] | c[6], c[4], c[3] | c[8], c[2:0], 8'h00};
      71: return rel_exp[15:0];
      72: return rel_exp[31:16];
      75: return m & 16'h001F;
      126: return w126_exp;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic run_id(input logic [8:0] cap, input logic stall);
    int got;
    int n;
    got = 0;
    n = 0;
    @(posedge clk_i);
    id_start_i <= 1'b1;
    @(posedge clk_i);
    id_start_i <= 1'b0;
    while (got < 256 && n < 4000) begin
      @(posedge clk_i);
      n++;
      if (word_valid_o === 1'b1 && word_ready_i === 1'b1) begin
        check(word_o.idx, got);
        check(word_o.data, exp_word(got, cap));
        check(id_busy_o, 1'b1);
        got++;
      end
      id_start_i <= (got == 100);
      word_ready_i <= !stall || n[1];
    end
    n = 0;
    while (id_done_o !== 1'b1 && n < 5) begin
      @(posedge clk_i);
      n++;
    end
    check(id_done_o, 1'b1);
    repeat (2) @(posedge clk_i);
    check(id_busy_o, 1'b0);
    word_ready_i <= 1'b1;
    $display("run_id cap %h done", cap);
  endtask

  task automatic do_cmd(input logic [15:0] bcl, input logic ab, input logic [15:0] lim);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_bcl_i <= bcl;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(posedge clk_i);
    check(cmd_done_o, 1'b1);
    check(cmd_res_o, {ab, lim});
  endtask

  task automatic test_regs();
    logic [31:0] q;
    logic [7:0]  adr[6] = '{REG_GENCFG, REG_CAP, REG_RELTIME, REG_BCZ, REG_STATUS, 8'h20};
    logic [31:0] ev[6] = '{{16'h0, RST_GENCFG}, {23'h0, RST_CAP}, {16'h0, RST_RELTIME},
                           {16'h0, RST_BCZ}, 32'h0, 32'h0};
    wb(8'h20, 1'b1, 32'hFFFF_FFFF, q);
    foreach (adr[k]) begin
      wb(adr[k], 1'b0, 32'h0, q);
      check(q, ev[k]);
    end
    $display("test_regs done");
  endtask

  task automatic test_bcz();
    logic [31:0] q;
    do_cmd(16'h0100, 1'b1, 16'h0100);
    do_cmd(16'h0000, 1'b0, 16'h0000);
    wb(REG_BCZ, 1'b1, 32'h0000_1234, q);
    do_cmd(16'h0000, 1'b0, 16'h0000);
    @(posedge clk_i);
    hw_reset_i <= 1'b1;
    @(posedge clk_i);
    hw_reset_i <= 1'b0;
    w126_exp = 16'h1234;
    do_cmd(16'h0000, 1'b0, 16'h1234);
    do_cmd(16'h0200, 1'b0, 16'h0200);
    wb(REG_BCZ, 1'b1, 32'h0000_5678, q);
    wb(REG_STATUS, 1'b0, 32'h0, q);
    check(q[15:0], 16'h1234);
    do_cmd(16'h0000, 1'b0, 16'h1234);
    $display("test_bcz done");
  endtask

  task automatic test_identify();
    logic [31:0] q;
    logic [8:0]  caps[3] = '{9'h140, 9'h0BF, 9'h100};
    wb(REG_RELTIME, 1'b1, 32'h0032_0014, q);
    wb(REG_GENCFG, 1'b1, 32'h0000_8580, q);
    rel_exp = 32'h0032_0014;
    gen_exp = 16'h8580;
    foreach (caps[k]) begin
      wb(REG_CAP, 1'b1, {23'h0, caps[k]}, q);
      run_id(caps[k], k[0]);
    end
    $display("test_identify done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    run_id(9'h000, 1'b1);
    test_bcz();
    test_identify();
    final_report();
  end
endmodule
